// [core/i2cs_pkg.sv]
// Shared constants and types of the I2C slave status and address block
package i2cs_pkg;

    // ========================================================================
    // Timing
    localparam int CLK_MHZ      = 50;
    localparam int HOLD_MIN_NS  = 300;
    localparam int HOLD_MIN_CYC = (HOLD_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_EXTRA   = 3;

    // ========================================================================
    // Register indices; the byte address is four times the index
    localparam logic [7:0]  IDX_SADR1 = 8'hDD;
    localparam logic [7:0]  IDX_CTRL  = 8'hDC;
    localparam logic [7:0]  IDX_STAT  = 8'hDB;
    localparam logic [7:0]  IDX_MASK  = 8'hDA;
    localparam logic [7:0]  IDX_DATA  = 8'hD9;
    localparam logic [11:0] A_SADR1   = {2'h0, IDX_SADR1, 2'h0};
    localparam logic [11:0] A_CTRL    = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] A_STAT    = {2'h0, IDX_STAT, 2'h0};
    localparam logic [11:0] A_MASK    = {2'h0, IDX_MASK, 2'h0};
    localparam logic [11:0] A_DATA    = {2'h0, IDX_DATA, 2'h0};

    // ========================================================================
    // Fields and reset values
    localparam int         SADR1_EN_BIT = 7;
    localparam int         CTRL_IGN_BIT = 4;
    localparam logic [7:0] SADR1_RST    = 8'h00;
    localparam logic [3:0] HOLD_RST     = 4'(HOLD_MIN_CYC - HOLD_EXTRA);
    localparam logic [2:0] SYNC_RST     = 3'h7;
    localparam logic [3:0] BITS_BYTE    = 4'h8;

    // Status: sticky event bits, then live levels
    localparam int ST_RPT   = 0;
    localparam int ST_STOP  = 1;
    localparam int ST_ADDR  = 2;
    localparam int ST_RXD   = 3;
    localparam int ST_NACKE = 4;
    localparam int NEV      = 5;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_ADDR = 7'h02,
        S_AACK = 7'h04,
        S_RX   = 7'h08,
        S_RACK = 7'h10,
        S_TX   = 7'h20,
        S_TACK = 7'h40
    } i2cs_state_t;

endpackage

// [core/i2cs_cond_if.sv]
// Bus condition events passed from the pin detector to the slave core
`timescale 1ns/100ps
interface i2cs_cond_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    modport det  (output scl_rise, scl_fall, start, stop, sda);
    modport core (input  scl_rise, scl_fall, start, stop, sda);
endinterface

// [core/i2cs_cond.sv]
// Pin synchroniser and START, STOP and clock edge detector
`timescale 1ns/100ps
module i2cs_cond import i2cs_pkg::*; (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  reset,
    // Bus pins
    input  wire logic  scl_pin,
    input  wire logic  sda_pin,
    // Events
    i2cs_cond_if.det   ev
);

    typedef struct packed {
        logic [2:0] scl;
        logic [2:0] sda;
    } i2cs_sync_t;

    i2cs_sync_t s_q;
    i2cs_sync_t s_d;

    // ========================================================================
    // Stage 0 is read only by stage 1; edges compare stages 1 and 2
    always_comb begin
        s_d     = s_q;
        s_d.scl = {s_q.scl[1:0], scl_pin};
        s_d.sda = {s_q.sda[1:0], sda_pin};
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= {SYNC_RST, SYNC_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign ev.scl_rise = s_q.scl[1] & ~s_q.scl[2];
    assign ev.scl_fall = ~s_q.scl[1] & s_q.scl[2];
    assign ev.start    = s_q.scl[1] & s_q.scl[2] & s_q.sda[2] & ~s_q.sda[1];
    assign ev.stop     = s_q.scl[1] & s_q.scl[2] & ~s_q.sda[2] & s_q.sda[1];
    assign ev.sda      = s_q.sda[1];

endmodule

// [core/i2cs_core.sv]
// I2C slave with status flags, SDA hold timing and primary address register
//
// Operation
// - Repeated START while the slave is not idle sets a sticky repeat start flag.
// - Start indicator sets on START plus address match, clears on STOP.
// - Master NACK after a transmitted byte sets the NACK status bit.
// - After master NACK the previous byte is resent until acknowledged.
// - NACK status clears on a new ACK and on a START condition.
// - SDA is held hold setting plus 3 clocks after SCL falls.
// - Address register: write enable and own address, read direction.
// - Direction bit reads one while transmitting, zero while receiving.
// - With the ignore option only address bits 6 to 1 are compared.
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
module i2cs_core import i2cs_pkg::*; (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // I2C pins, open drain
    input  wire logic        scl_pin,
    input  wire logic        sda_pin,
    output logic             sda_out,
    output logic             sda_oe,
    // Interrupt
    output logic             irq
);

    typedef struct packed {
        i2cs_state_t       st;
        logic [3:0]        cnt;
        logic [7:0]        sh;
        logic [7:0]        txsh;
        logic [7:0]        txlast;
        logic [7:0]        txdat;
        logic [7:0]        rxdat;
        logic [6:0]        own;
        logic              en;
        logic [6:0]        raddr;
        logic              dir;
        logic [3:0]        hold;
        logic              ign;
        logic [4:0]        hcnt;
        logic              oe;
        logic              sdo;
        logic [NEV-1:0]    stk;
        logic [NEV-1:0]    mask;
        logic              start_ind;
        logic              nack;
        logic              resend;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic              irq;
    } i2cs_core_t;

    i2cs_core_t s_q;
    i2cs_core_t s_d;

    i2cs_cond_if pin ();

    i2cs_cond u_cond (
        .clk     (clk),
        .reset   (reset),
        .scl_pin (scl_pin),
        .sda_pin (sda_pin),
        .ev      (pin)
    );

    // ========================================================================
    // Helpers
    function automatic logic addr_hit(input logic [6:0] rx,
                                      input logic [6:0] own,
                                      input logic       ign);
        if (ign) begin
            addr_hit = (rx[6:1] == own[6:1]);
        end else begin
            addr_hit = (rx == own);
        end
    endfunction

    function automatic logic drive_low(input i2cs_state_t st,
                                       input logic        msb);
        drive_low = (st == S_AACK) || (st == S_RACK) ||
                    ((st == S_TX) && !msb);
    endfunction

    logic [NEV-1:0] ev_set;
    logic [NEV-1:0] ev_clr;
    logic [31:0]    rd_val;
    logic           mapped;
    logic           apb_done;

    // ========================================================================
    // Register read mux
    always_comb begin
        rd_val = 32'h0;
        mapped = 1'b1;
        case (paddr)
            A_SADR1: rd_val = {24'h0, s_q.dir, s_q.raddr};
            A_CTRL:  rd_val = {27'h0, s_q.ign, s_q.hold};
            A_STAT:  rd_val = {25'h0, s_q.nack, s_q.start_ind, s_q.stk};
            A_MASK:  rd_val = {27'h0, s_q.mask};
            A_DATA:  rd_val = {24'h0, s_q.rxdat};
            default: mapped = 1'b0;
        endcase
    end

    assign apb_done = psel && penable && s_q.pready;

    // ========================================================================
    // Next state
    always_comb begin
        s_d    = s_q;
        ev_set = '0;
        ev_clr = '0;

        // APB: one wait state, answer registered in the access phase
        s_d.pready = psel && penable && !s_q.pready;
        if (psel && penable && !s_q.pready) begin
            s_d.pslverr = !mapped;
            s_d.prdata  = pwrite ? 32'h0 : rd_val;
        end
        if (apb_done && pwrite) begin
            case (paddr)
                A_SADR1: begin
                    s_d.en  = pwdata[SADR1_EN_BIT];
                    s_d.own = pwdata[6:0];
                end
                A_CTRL: begin
                    s_d.ign  = pwdata[CTRL_IGN_BIT];
                    s_d.hold = pwdata[3:0];
                end
                A_MASK:  s_d.mask  = pwdata[NEV-1:0];
                A_DATA:  s_d.txdat = pwdata[7:0];
                default: ;
            endcase
        end
        // Only bits already reported are cleared, so a late event survives
        if (apb_done && !pwrite && paddr == A_STAT) begin
            ev_clr = s_q.prdata[NEV-1:0];
        end

        // Hold counter ends SDA changes a fixed time after SCL falls
        if (s_q.hcnt != 5'h0) begin
            s_d.hcnt = s_q.hcnt - 5'h1;
            if (s_q.hcnt == 5'h1) begin
                s_d.oe = drive_low(s_q.st, s_q.txsh[7]);
            end
        end

        if (pin.stop) begin
            s_d.st        = S_IDLE;
            s_d.start_ind = 1'b0;
            s_d.hcnt      = 5'h0;
            s_d.oe        = 1'b0;
            ev_set[ST_STOP] = 1'b1;
        end else if (pin.start) begin
            // Repeated START: a START while a transfer is open
            if (s_q.st != S_IDLE) begin
                ev_set[ST_RPT] = 1'b1;
            end
            s_d.st   = S_ADDR;
            s_d.cnt  = 4'h0;
            s_d.nack = 1'b0;
            s_d.hcnt = 5'h0;
            s_d.oe   = 1'b0;
        end else begin
            if (pin.scl_rise) begin
                case (s_q.st)
                    S_ADDR, S_RX: begin
                        s_d.sh  = {s_q.sh[6:0], pin.sda};
                        s_d.cnt = s_q.cnt + 4'h1;
                    end
                    S_TX: s_d.cnt = s_q.cnt + 4'h1;
                    S_TACK: begin
                        if (pin.sda) begin
                            s_d.nack   = 1'b1;
                            s_d.resend = 1'b1;
                            ev_set[ST_NACKE] = 1'b1;
                        end else begin
                            s_d.nack   = 1'b0;
                            s_d.resend = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
            if (pin.scl_fall) begin
                s_d.hcnt = 5'(s_q.hold) + 5'(HOLD_EXTRA);
                case (s_q.st)
                    S_ADDR: begin
                        if (s_q.cnt == BITS_BYTE) begin
                            if (s_q.en &&
                                addr_hit(s_q.sh[7:1], s_q.own, s_q.ign)) begin
                                s_d.st        = S_AACK;
                                s_d.raddr     = s_q.sh[7:1];
                                s_d.dir       = s_q.sh[0];
                                s_d.start_ind = 1'b1;
                                ev_set[ST_ADDR] = 1'b1;
                            end else begin
                                s_d.st = S_IDLE;
                            end
                        end
                    end
                    S_AACK: begin
                        s_d.cnt = 4'h0;
                        if (s_q.dir) begin
                            s_d.st = S_TX;
                            // After a NACK the old byte goes out again
                            if (s_q.resend) begin
                                s_d.txsh = s_q.txlast;
                            end else begin
                                s_d.txsh   = s_q.txdat;
                                s_d.txlast = s_q.txdat;
                            end
                        end else begin
                            s_d.st = S_RX;
                        end
                    end
                    S_RX: begin
                        if (s_q.cnt == BITS_BYTE) begin
                            s_d.st    = S_RACK;
                            s_d.rxdat = s_q.sh;
                            ev_set[ST_RXD] = 1'b1;
                        end
                    end
                    S_RACK: begin
                        s_d.st  = S_RX;
                        s_d.cnt = 4'h0;
                    end
                    S_TX: begin
                        if (s_q.cnt == BITS_BYTE) begin
                            s_d.st = S_TACK;
                        end else begin
                            s_d.txsh = {s_q.txsh[6:0], 1'b1};
                        end
                    end
                    S_TACK: begin
                        if (s_q.resend) begin
                            s_d.st = S_IDLE;
                        end else begin
                            s_d.st     = S_TX;
                            s_d.cnt    = 4'h0;
                            s_d.txsh   = s_q.txdat;
                            s_d.txlast = s_q.txdat;
                        end
                    end
                    default: s_d.st = S_IDLE;
                endcase
            end
        end

        // Set wins over a clear in the same cycle
        s_d.stk = (s_q.stk & ~ev_clr) | ev_set;
        s_d.irq = |(s_d.stk & s_d.mask);
    end

    // ========================================================================
    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q           <= '0;
            s_q.st        <= S_IDLE;
            s_q.en        <= SADR1_RST[SADR1_EN_BIT];
            s_q.own       <= SADR1_RST[6:0];
            s_q.hold      <= HOLD_RST;
            s_q.txsh      <= 8'hFF;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata  = s_q.prdata;
    assign pready  = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign sda_out = s_q.sdo;
    assign sda_oe  = s_q.oe;
    assign irq     = s_q.irq;

    // ========================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_rpt_start_flag: assert property (
        pin.start && !pin.stop && s_q.st != S_IDLE |=> s_q.stk[ST_RPT])
        else $error("repeated START did not set the flag");

    a_start_ind_stop: assert property (
        pin.stop |=> !s_q.start_ind ##1 !s_q.start_ind || s_q.st != S_IDLE)
        else $error("start indicator survived STOP");

    a_nack_set: assert property (
        s_q.st == S_TACK && pin.scl_rise && pin.sda && !pin.start
        && !pin.stop |=> s_q.nack && s_q.stk[ST_NACKE])
        else $error("master NACK not flagged");

    a_resend_byte: assert property (
        s_q.st == S_AACK && pin.scl_fall && s_q.dir && s_q.resend
        && !pin.start && !pin.stop |=> s_q.txsh == $past(s_q.txlast))
        else $error("old byte not resent after NACK");

    a_nack_clear: assert property (
        pin.start |=> !s_q.nack)
        else $error("NACK status not cleared by START");

    a_hold_time: assert property (
        pin.scl_fall && !pin.start && !pin.stop |=> $stable(s_q.oe)[*3])
        else $error("SDA changed inside the hold time");

    a_hold_change: assert property (
        $changed(s_q.oe) |-> $past(s_q.hcnt) == 5'h1 || $past(pin.start)
        || $past(pin.stop))
        else $error("SDA drive changed outside the hold count");

    a_addr_readback: assert property (
        s_q.pready && psel && !pwrite && paddr == A_SADR1
        |-> s_q.prdata == {24'h0, $past(s_q.dir), $past(s_q.raddr)})
        else $error("address register read-back wrong");

    a_dir_transmit: assert property (
        s_q.st == S_TX || s_q.st == S_TACK |-> s_q.dir)
        else $error("direction clear during transmit");

    a_lsb_compare: assert property (
        $rose(s_q.st == S_AACK) |-> s_q.raddr[6:1] == s_q.own[6:1]
        && (s_q.ign || s_q.raddr[0] == s_q.own[0]))
        else $error("address compared wrongly");

    a_enable_gate: assert property (
        s_q.st == S_ADDR && pin.scl_fall && !s_q.en |=> s_q.st != S_AACK)
        else $error("disabled slave acknowledged");

endmodule

// [testbench/i2cs_master_model.sv]
// Behavioural I2C bus master that drives SCL and pulls SDA low
`timescale 1ns/100ps
module i2cs_master_model #(
    parameter int Q_NS = 600
) (
    // Bus
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_line
);
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // ========================================================================
    // Bit and frame tasks
    // SDA moves a quarter period after SCL falls, well past the hold window
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        #(Q_NS);
        scl = 1'b1;
        #(Q_NS);
        r = sda_line;
        #(Q_NS);
        scl = 1'b0;
        #(Q_NS);
    endtask

    // Also used as repeated START; SCL stands high between frames
    task automatic start();
        sda_low = 1'b0;
        #(Q_NS);
        scl = 1'b1;
        #(Q_NS);
        sda_low = 1'b1;
        #(Q_NS);
        scl = 1'b0;
        #(Q_NS);
    endtask

    task automatic stop();
        sda_low = 1'b1;
        #(Q_NS);
        scl = 1'b1;
        #(Q_NS);
        sda_low = 1'b0;
        #(Q_NS);
    endtask

    // Byte MSB first, then the ninth bit; mack drives ACK low
    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] r, output logic sack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(!mack, a);
        sack = !a;
    endtask
endmodule

// [testbench/i2c_slave_status_and_address_tb_top.sv]
// Self-checking bench for the I2C slave status and address block
`timescale 1ns/100ps
module i2c_slave_status_and_address_tb_top;
    import i2cs_pkg::*;
    logic        clk         = 1'b0;
    logic        reset       = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sda_out;
    logic        sda_oe;
    logic        irq;
    logic        scl;
    logic        m_low;
    logic        scl_q       = 1'b1;
    logic        sda_q       = 1'b1;
    wire         sda_line;
    int          n_fail      = 0;
    int          checks_done = 0;
    int          seed        = 32'hF4C1;
    realtime     t_fall;
    int          hold_ns;

    // Open drain with pull-up
    assign sda_line = !(m_low || (sda_oe && !sda_out));
    always #10 clk = ~clk;
    always @(negedge scl) t_fall = $realtime;
    always @(posedge sda_oe) hold_ns = int'($realtime - t_fall);

    // Bus levels reach the design by a bench flop, changing only at a rising clock edge
    always @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda_line;
    end

    i2cs_core dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_pin(scl_q),
        .sda_pin(sda_q), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq)
    );
    i2cs_master_model m (.scl(scl), .sda_low(m_low), .sda_line(sda_line));

    // ========================================================================
    // Expectations, compares and bus tasks
    // Bench flop and pin synchroniser add three or four clocks before the
    // hold count starts
    function automatic logic [31:0] hold_ok(input int d, input int h);
        return 32'(d >= (h + 5) * 20 && d <= (h + 8) * 20 && d >= 300);
    endfunction

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a,
                          input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(what, exp, r);
    endtask

    task automatic frame(input logic [7:0] a, output logic ack);
        logic [7:0] r8;
        m.start();
        m.xfer(a, 1'b0, r8, ack);
        m.stop();
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #(1_000_000);
        n_fail++;
        tally_and_finish();
    end

    // ========================================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        logic        e;
        logic        ack;
        logic [7:0]  b;
        logic [7:0]  x;
        logic [7:0]  y;
        logic [6:0]  own;
        int          h;
        own = 7'($random(seed));
        x = 8'($random(seed));
        y = 8'($random(seed));
        h = 12 + ($random(seed) & 3);
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk("sadr1 reset", A_SADR1, 32'(SADR1_RST));
        rd_chk("ctrl reset", A_CTRL, 32'(HOLD_RST));
        rd_chk("status reset", A_STAT, 32'h0);
        apb(1'b0, 12'h000, 32'h0, r, e);
        check("unmapped err", 32'h1, 32'(e));
        check("unmapped data", 32'h0, r);
        $display("test reset finished");

        wr(A_SADR1, {25'h0, own});
        frame({own, 1'b0}, ack);
        check("disabled ack", 32'h0, 32'(ack));
        wr(A_SADR1, {24'h0, 1'b1, own});
        frame({own ^ 7'h04, 1'b0}, ack);
        check("foreign ack", 32'h0, 32'(ack));
        for (int g = 1; g >= 0; g--) begin
            wr(A_CTRL, 32'(g * 16 + h));
            frame({own ^ 7'h01, 1'b0}, ack);
            check("lsb ignore ack", 32'(g), 32'(ack));
            if (g == 1) begin
                check("hold", 32'h1, hold_ok(hold_ns, h));
                check("sda out", 32'h0, 32'(sda_out));
            end
        end
        $display("test address match finished");

        apb(1'b0, A_STAT, 32'h0, r, e);
        m.start();
        m.xfer({own, 1'b0}, 1'b0, b, ack);
        check("own ack", 32'h1, 32'(ack));
        m.xfer(x, 1'b0, b, ack);
        rd_chk("rx dir", A_SADR1, {24'h0, 1'b0, own});
        check("irq masked", 32'h0, 32'(irq));
        rd_chk("status open", A_STAT, 32'h2C);
        rd_chk("rx data", A_DATA, 32'(x));
        wr(A_MASK, 32'h2);
        m.stop();
        check("irq stop", 32'h1, 32'(irq));
        rd_chk("status stop", A_STAT, 32'h02);
        repeat (2) @(posedge clk);
        check("irq clear", 32'h0, 32'(irq));
        $display("test receive finished");

        // Write phase, repeated START, then read phase ended by NACK
        wr(A_DATA, 32'(x));
        m.start();
        m.xfer({own, 1'b0}, 1'b0, b, ack);
        m.start();
        rd_chk("rpt set", A_STAT, 32'h25);
        rd_chk("rpt read clr", A_STAT, 32'h20);
        m.xfer({own, 1'b1}, 1'b0, b, ack);
        rd_chk("tx dir", A_SADR1, {24'h0, 1'b1, own});
        m.xfer(8'hFF, 1'b0, b, ack);
        check("tx byte", 32'(x), 32'(b));
        rd_chk("nack set", A_STAT, 32'h74);
        m.stop();
        wr(A_DATA, 32'(y));
        m.start();
        m.xfer({own, 1'b1}, 1'b0, b, ack);
        rd_chk("nack start clr", A_STAT, 32'h26);
        m.xfer(8'hFF, 1'b1, b, ack);
        check("resend", 32'(x), 32'(b));
        m.xfer(8'hFF, 1'b0, b, ack);
        check("next byte", 32'(y), 32'(b));
        m.stop();
        $display("test transmit finished");
        tally_and_finish();
    end
endmodule
